// *** rtl/pwm_output_cond.sv ***
/*
 * output-conditioning stage of an enhanced pwm: auto-shutdown with safe
 * pin states, auto-restart, half-bridge dead band and pulse steering.
 * assumes the pwm wave and period start come from the period generator on
 * i_clk, one clock equals one instruction cycle, and software reaches the
 * registers over apb.
 */
// How it works
// (RULE1) source field picks comparators and fault pin
// (RULE2) firmware setting flag is a shutdown event
// (RULE3) event sets flag until cleared or restarted
// (RULE4) outputs forced combinationally, no clock wait
// (RULE5) a/c pair: low, high or tri-state
// (RULE6) b/d pair: low, high or tri-state
// (RULE7) flag reads one while outputs shut down
// (RULE8) shutdown held while source level present
// (RULE9) flag writes ignored while condition present
// (RULE10) restart waits for next pwm period
// (RULE11) auto-restart clears flag when condition goes
// (RULE12) without auto-restart, software clears the flag
// (RULE13) dead band delays only inactive-to-active edges
// (RULE14) seven-bit dead-band count in instruction cycles
// (RULE15) steering only in single-output pwm mode
// (RULE16) same wave on every steered pin
// (RULE17) low mode bits set steered polarity
// (RULE18) shutdown forces only pwm-enabled pins
// (RULE19) dead band beyond duty keeps output inactive
// (RULE20) sync bit picks period or immediate steering
// (RULE21) inputs synchronised, forcing path combinational
`timescale 1ns/1ps
module pwm_output_cond #(
  parameter int DB_WIDTH = 7
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire pwm_cond_pkg::pwm_src_type i_pwm,
  input wire logic [3:0] i_port_level,
  input wire logic i_fault_input_pin_b,
  input wire logic i_comparator1_output,
  input wire logic i_comparator2_output,
  output pwm_cond_pkg::pin_bus_type o_pins
);
  import pwm_cond_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic shutdown_event_flag;
  logic [2:0] shutdown_source_select;
  logic [1:0] pair_ac_shutdown_state;
  logic [1:0] pair_bd_shutdown_state;
  logic auto_restart_enable;
  logic [DB_WIDTH-1:0] deadband_count;
  logic steering_sync_select;
  logic [3:0] steering_pin_enables;
  logic [3:0] steer_active;
  logic [1:0] capture_mode_upper;
  logic [1:0] output_polarity_select;
  logic [1:0] output_config_field;
  logic running;

  //////////////////////////////////////////////////////////////////////////
  // apb decode
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic flag_wr;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && !i_penable && !i_pwrite;
  assign addr_ok = (i_paddr == addr_shutdown_ctl) ||
                   (i_paddr == addr_restart_ctl) ||
                   (i_paddr == addr_steer_ctl) ||
                   (i_paddr == addr_mode_ctl);
  assign flag_wr = wr_en && (i_paddr == addr_shutdown_ctl);
  assign o_pready = 1'b1; // zero wait states
  assign o_pslverr = i_psel && i_penable && !addr_ok;

  //////////////////////////////////////////////////////////////////////////
  // synchronised shutdown sources
  logic fault_b_s;
  logic cmp1_s;
  logic cmp2_s;

  sync3 #(.RESET_VALUE(1'b1)) u_sync_fault (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_async(i_fault_input_pin_b), .o_level(fault_b_s)); // [RULE21]

  sync3 #(.RESET_VALUE(1'b0)) u_sync_cmp1 (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_async(i_comparator1_output), .o_level(cmp1_s)); // [RULE21]

  sync3 #(.RESET_VALUE(1'b0)) u_sync_cmp2 (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_async(i_comparator2_output), .o_level(cmp2_s)); // [RULE21]

  // source condition, raw for forcing and synchronised for the flag
  logic cond_raw;
  logic cond_sync;
  assign cond_raw =
    (shutdown_source_select[0] && i_comparator1_output) ||
    (shutdown_source_select[1] && i_comparator2_output) ||
    (shutdown_source_select[2] && !i_fault_input_pin_b); // [RULE1]
  assign cond_sync =
    (shutdown_source_select[0] && cmp1_s) ||
    (shutdown_source_select[1] && cmp2_s) ||
    (shutdown_source_select[2] && !fault_b_s); // [RULE1]

  //////////////////////////////////////////////////////////////////////////
  // shutdown flag: set wins over clear; writes blocked under condition
  logic sw_set;
  logic sw_clr;
  assign sw_set = flag_wr && i_pwdata[pos_flag] && !cond_sync; // [RULE2]
  assign sw_clr = flag_wr && !i_pwdata[pos_flag] && !cond_sync; // [RULE9]

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      shutdown_event_flag <= 1'b0;
    end else if (cond_sync || sw_set) begin
      shutdown_event_flag <= 1'b1; // [RULE3] [RULE8]
    end else if (auto_restart_enable) begin
      shutdown_event_flag <= 1'b0; // [RULE11]
    end else if (sw_clr) begin
      shutdown_event_flag <= 1'b0; // [RULE12]
    end
  end

  // outputs resume only at a period start after the flag drops
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      running <= 1'b0;
    end else if (shutdown_event_flag || cond_sync) begin
      running <= 1'b0;
    end else if (i_pwm.period_start) begin
      running <= 1'b1; // [RULE10]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // remaining register writes
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      shutdown_source_select <= rst_shutdown_ctl[pos_src +: 3];
      pair_ac_shutdown_state <= rst_shutdown_ctl[pos_ac +: 2];
      pair_bd_shutdown_state <= rst_shutdown_ctl[pos_bd +: 2];
    end else if (flag_wr) begin
      shutdown_source_select <= i_pwdata[pos_src +: 3];
      pair_ac_shutdown_state <= i_pwdata[pos_ac +: 2];
      pair_bd_shutdown_state <= i_pwdata[pos_bd +: 2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      auto_restart_enable <= rst_restart_ctl[pos_restart];
      deadband_count <= DB_WIDTH'(rst_restart_ctl);
    end else if (wr_en && i_paddr == addr_restart_ctl) begin
      auto_restart_enable <= i_pwdata[pos_restart];
      deadband_count <= i_pwdata[DB_WIDTH-1:0]; // [RULE14]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      steering_sync_select <= rst_steer_ctl[pos_sync];
      steering_pin_enables <= rst_steer_ctl[3:0];
    end else if (wr_en && i_paddr == addr_steer_ctl) begin
      steering_sync_select <= i_pwdata[pos_sync];
      steering_pin_enables <= i_pwdata[3:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      output_config_field <= rst_mode_ctl[pos_cfg +: 2];
      capture_mode_upper <= rst_mode_ctl[3:2];
      output_polarity_select <= rst_mode_ctl[1:0];
    end else if (wr_en && i_paddr == addr_mode_ctl) begin
      output_config_field <= i_pwdata[pos_cfg +: 2];
      capture_mode_upper <= i_pwdata[3:2];
      output_polarity_select <= i_pwdata[1:0];
    end
  end

  // effective steering: immediate or at next period
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      steer_active <= rst_steer_ctl[3:0];
    end else if (!steering_sync_select || i_pwm.period_start) begin
      steer_active <= steering_pin_enables; // [RULE20]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data captured in the setup cycle; stands at the access edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (i_paddr)
        addr_shutdown_ctl: o_prdata <= {24'h00_0000, shutdown_event_flag,
          shutdown_source_select, pair_ac_shutdown_state,
          pair_bd_shutdown_state}; // [RULE7]
        addr_restart_ctl: o_prdata <= {24'h00_0000, auto_restart_enable,
          deadband_count};
        addr_steer_ctl: o_prdata <= {27'h000_0000, steering_sync_select,
          steering_pin_enables};
        addr_mode_ctl: o_prdata <= {26'h000_0000, output_config_field,
          capture_mode_upper, output_polarity_select};
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // waveform shaping
  logic pwm_mode;
  logic steering_mode;
  logic half_mode;
  logic wave_a;
  logic wave_b;
  logic db_a;
  logic db_b;
  assign pwm_mode = capture_mode_upper == mode_pwm;
  assign steering_mode = pwm_mode &&
                         (output_config_field == cfg_single); // [RULE15]
  assign half_mode = pwm_mode && (output_config_field == cfg_half);
  assign wave_a = i_pwm.wave && running;
  assign wave_b = !i_pwm.wave && running;

  deadband_delay #(.WIDTH(DB_WIDTH)) u_db_a (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_wave(wave_a),
    .i_count(deadband_count),
    .o_wave(db_a)
  ); // [RULE13] [RULE19]

  deadband_delay #(.WIDTH(DB_WIDTH)) u_db_b (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_wave(wave_b),
    .i_count(deadband_count),
    .o_wave(db_b)
  ); // [RULE13] [RULE19]

  // logical wave per pin and which pins the pwm owns
  logic [3:0] logical;
  logic [3:0] owned;
  always_comb begin
    logical = 4'h0;
    owned = 4'h0;
    if (steering_mode) begin
      logical = {4{wave_a}}; // [RULE16]
      owned = steer_active; // [RULE16]
    end else if (half_mode) begin
      logical = {2'b00, db_b, db_a}; // [RULE13]
      owned = 4'h3;
    end else if (pwm_mode) begin
      logical = {4{wave_a}};
      owned = 4'hf;
    end
  end

  // polarity: bit0 inverts a/c, bit1 inverts b/d
  logic [3:0] polar;
  assign polar = {output_polarity_select[1], output_polarity_select[0],
                  output_polarity_select[1],
                  output_polarity_select[0]}; // [RULE17]

  //////////////////////////////////////////////////////////////////////////
  // pin drive with combinational shutdown override
  logic shut_now;
  assign shut_now = shutdown_event_flag || cond_raw; // [RULE4] [RULE21]

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_pins.level[i] = i_port_level[i];
      o_pins.oe[i] = 1'b1;
      if (owned[i]) begin
        o_pins.level[i] = logical[i] ^ polar[i];
        if (shut_now) begin
          if (i == 0 || i == 2) begin
            o_pins.level[i] = pair_ac_shutdown_state[0]; // [RULE5]
            o_pins.oe[i] = !pair_ac_shutdown_state[1]; // [RULE5]
          end else begin
            o_pins.level[i] = pair_bd_shutdown_state[0]; // [RULE6]
            o_pins.oe[i] = !pair_bd_shutdown_state[1]; // [RULE6]
          end
        end
      end
    end
  end // [RULE18]

  //////////////////////////////////////////////////////////////////////////
  // assertions
  property p_flag_sets;
    @(posedge i_clk) disable iff (!i_rst_b)
      cond_sync |=> shutdown_event_flag;
  endproperty
  a_flag_sets: assert property (p_flag_sets) // [RULE3]
    else $error("flag not set by condition");
  property p_fw_set;
    @(posedge i_clk) disable iff (!i_rst_b)
      flag_wr && i_pwdata[pos_flag] |=> shutdown_event_flag;
  endproperty
  a_fw_set: assert property (p_fw_set) // [RULE2]
    else $error("firmware set ignored");
  property p_no_clear_under_cond;
    @(posedge i_clk) disable iff (!i_rst_b)
      cond_sync && shutdown_event_flag |=> shutdown_event_flag;
  endproperty
  a_no_clear_under_cond: assert property (p_no_clear_under_cond) // [RULE9]
    else $error("flag cleared while condition present");
  property p_auto_clear;
    @(posedge i_clk) disable iff (!i_rst_b)
      auto_restart_enable && !cond_sync && !sw_set && shutdown_event_flag
      |=> !shutdown_event_flag;
  endproperty
  a_auto_clear: assert property (p_auto_clear) // [RULE11]
    else $error("auto restart did not clear flag");
  property p_sticky;
    @(posedge i_clk) disable iff (!i_rst_b)
      !auto_restart_enable && shutdown_event_flag && !sw_clr
      |=> shutdown_event_flag;
  endproperty
  a_sticky: assert property (p_sticky) // [RULE12]
    else $error("flag dropped without software clear");
  property p_forced_ac;
    @(posedge i_clk) disable iff (!i_rst_b)
      shutdown_event_flag && owned[0] && pair_ac_shutdown_state == pss_high
      |-> o_pins.level[0] && o_pins.oe[0];
  endproperty
  a_forced_ac: assert property (p_forced_ac) // [RULE5]
    else $error("pin a not forced high");
  property p_forced_bd;
    @(posedge i_clk) disable iff (!i_rst_b)
      shutdown_event_flag && owned[1] && pair_bd_shutdown_state[1]
      |-> !o_pins.oe[1];
  endproperty
  a_forced_bd: assert property (p_forced_bd) // [RULE6]
    else $error("pin b not released");
  property p_restart_at_period;
    @(posedge i_clk) disable iff (!i_rst_b)
      !running ##1 running |-> $past(i_pwm.period_start);
  endproperty
  a_restart_at_period: assert property (p_restart_at_period) // [RULE10]
    else $error("restart away from period start");
  property p_unsteered_port;
    @(posedge i_clk) disable iff (!i_rst_b)
      steering_mode && !steer_active[2]
      |-> o_pins.level[2] == i_port_level[2];
  endproperty
  a_unsteered_port: assert property (p_unsteered_port) // [RULE18]
    else $error("unsteered pin disturbed");
  c_shutdown: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    cond_sync ##1 shutdown_event_flag);
  c_auto_restart: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    shutdown_event_flag ##1 !shutdown_event_flag ##[1:50] running);
  c_steer: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    steering_mode && steer_active == 4'hf);
endmodule

// *** rtl/pwm_cond_pkg.sv ***
/*
 * package for the pwm output-conditioning stage: register offsets, field
 * positions, reset values, mode codes and the carrier structs.
 * assumes a 32-bit apb slave with one register per aligned word.
 */
package pwm_cond_pkg;

  // register byte addresses
  localparam logic [7:0] addr_shutdown_ctl = 8'h00;
  localparam logic [7:0] addr_restart_ctl = 8'h04;
  localparam logic [7:0] addr_steer_ctl = 8'h08;
  localparam logic [7:0] addr_mode_ctl = 8'h0c;

  // reset values
  localparam logic [7:0] rst_shutdown_ctl = 8'h00;
  localparam logic [7:0] rst_restart_ctl = 8'h00;
  localparam logic [4:0] rst_steer_ctl = 5'h01;
  localparam logic [5:0] rst_mode_ctl = 6'h00;

  // field positions
  localparam int pos_flag = 7;
  localparam int pos_src = 4;
  localparam int pos_ac = 2;
  localparam int pos_bd = 0;
  localparam int pos_restart = 7;
  localparam int pos_sync = 4;
  localparam int pos_cfg = 4;

  // shutdown source select bits
  localparam logic [2:0] src_cmp1 = 3'h1;
  localparam logic [2:0] src_cmp2 = 3'h2;
  localparam logic [2:0] src_fault = 3'h4;

  // pin-pair shutdown states
  localparam logic [1:0] pss_low = 2'h0;
  localparam logic [1:0] pss_high = 2'h1;

  // output configurations and mode
  localparam logic [1:0] cfg_single = 2'h0;
  localparam logic [1:0] cfg_half = 2'h2;
  localparam logic [1:0] mode_pwm = 2'h3;

  // dead-band unit: one instruction cycle is four oscillator periods
  localparam int tosc_per_tcy = 4;
  localparam int clk_per_tcy = 1;

  // four output pins as one bundle
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pin_bus_type;

  // raw pwm inputs from the period/duty generator
  typedef struct packed {
    logic wave;
    logic period_start;
  } pwm_src_type;

endpackage

// *** rtl/sync3.sv ***
/*
 * three-flop synchroniser for an outside level; a change counts once the
 * second and third stages agree.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module sync3 #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_async,
  output logic o_level
);
  logic s1;
  logic s2;
  logic s3;

  // shift chain; only s2 reads s1
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      s1 <= RESET_VALUE;
      s2 <= RESET_VALUE;
      s3 <= RESET_VALUE;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // held value updates when the two later stages agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_level <= RESET_VALUE;
    end else if (s2 == s3) begin
      o_level <= s3;
    end
  end
endmodule

// *** rtl/deadband_delay.sv ***
/*
 * dead-band delay for one output: rising (inactive to active) edges are
 * postponed by a count of instruction cycles, falling edges pass at once.
 * assumes the input is an active-high logical waveform on i_clk.
 */
`timescale 1ns/1ps
module deadband_delay #(
  parameter int WIDTH = 7
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wave,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_wave
);
  logic [WIDTH-1:0] elapsed;

  // count cycles spent active; output goes active once count reached
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      elapsed <= '0;
    end else if (!i_wave) begin
      elapsed <= '0;
    end else if (elapsed != i_count) begin
      elapsed <= elapsed + WIDTH'(1);
    end
  end

  // inactive edge is immediate; short pulses never go active
  assign o_wave = i_wave && (elapsed == i_count);
endmodule

// *** test/bridge_model.sv ***
/*
 * far-side model: pwm generator feeding the block, and the bridge gate
 * lines with pull-downs that read the block's pins.
 * assumes one clock; the bench drives fault and comparator lines itself.
 */
`timescale 1ns/1ps
module bridge_model #(
  parameter int PERIOD = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [4:0] i_duty,
  input wire pwm_cond_pkg::pin_bus_type i_pins,
  output pwm_cond_pkg::pwm_src_type o_pwm,
  output logic [3:0] o_wire
);
  import pwm_cond_pkg::*;
  logic [4:0] phase;
  ////////////////////////////////////////////////////////////////////////
  // free-running period counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || phase >= 5'(PERIOD - 1)) begin
      phase <= 5'h00;
    end else begin
      phase <= phase + 5'h01;
    end
  end
  // duty 16 keeps the wave high, 0 keeps it low
  assign o_pwm.period_start = (phase == 5'h00);
  assign o_pwm.wave = (phase < i_duty);
  // released gate lines are pulled low so a tri-state never reads high
  assign o_wire = i_pins.level & i_pins.oe;
endmodule

// *** test/tb_top.sv ***
/*
 * self-checking bench for pwm_output_cond: registers over apb, steering,
 * shutdown sources, restart and dead band.
 * assumes bridge_model as the far side and zero-wait apb reads.
 */
`timescale 1ns/1ps
module tb_top;
  import pwm_cond_pkg::*;
  logic i_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic flt_b = 1'b1;
  logic c1 = 1'b0;
  logic c2 = 1'b0;
  logic [3:0] port = 4'h0;
  logic [4:0] duty = 5'h10;
  pwm_src_type pwm;
  pin_bus_type pins;
  logic [3:0] wire_lvl;
  logic [31:0] q;
  int n_fail = 0;
  int checks = 0;

  pwm_output_cond dut (.i_clk(i_clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pwm(pwm), .i_port_level(port), .i_fault_input_pin_b(flt_b),
    .i_comparator1_output(c1), .i_comparator2_output(c2), .o_pins(pins));
  bridge_model far (.i_clk(i_clk), .i_rst_b(rst_b), .i_duty(duty),
    .i_pins(pins), .o_pwm(pwm), .o_wire(wire_lvl));

  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic err);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    err = pslverr;
    q = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
    if (n >= 50) begin
      n_fail++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask

  task automatic rd(input logic [7:0] a);
    logic e;
    apb(1'b0, a, 32'h0, e);
  endtask

  function automatic logic [7:0] pv();
    return {pins.oe, wire_lvl};
  endfunction

  // stop just after the edge that opens a pwm period
  task automatic align();
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (pwm.period_start !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    logic e;
    rd(addr_shutdown_ctl);
    chk("sd_rst", 32'(rst_shutdown_ctl), q);
    rd(addr_restart_ctl);
    chk("rr_rst", 32'(rst_restart_ctl), q);
    rd(addr_steer_ctl);
    chk("st_rst", 32'(rst_steer_ctl), q);
    wr(addr_restart_ctl, 32'hffffffff);
    rd(addr_restart_ctl);
    chk("rr_rw", 32'hff, q);
    wr(addr_restart_ctl, 32'h0);
    apb(1'b0, 8'h40, 32'h0, e);
    chk("unmap_err", 32'h1, 32'(e));
    chk("unmap_rd", 32'h0, q);
    $display("test regs done");
  endtask

  task automatic t_steer();
    port <= 4'h6;
    wr(addr_mode_ctl, 32'h00);
    cyc(2);
    chk("no_steer", 32'hf6, 32'(pv()));
    wr(addr_steer_ctl, 32'h05);
    wr(addr_mode_ctl, 32'(6'h0c));
    cyc(40);
    chk("steer_sub", 32'hf7, 32'(pv()));
    wr(addr_steer_ctl, 32'h0f);
    for (int p = 0; p < 4; p++) begin
      wr(addr_mode_ctl, 32'({cfg_single, mode_pwm, p[1:0]}));
      cyc(4);
      chk("pol", 32'hff ^ 32'({p[1:0], p[1:0]}), 32'(pv()));
    end
    wr(addr_mode_ctl, 32'(6'h0c));
    port <= 4'h0;
    align();
    wr(addr_steer_ctl, 32'h11);
    chk("sync_hold", 32'hff, 32'(pv()));
    cyc(20);
    chk("sync_done", 32'hf1, 32'(pv()));
    wr(addr_steer_ctl, 32'h0f);
    cyc(1);
    chk("sync_now", 32'hff, 32'(pv()));
    $display("test steer done");
  endtask

  task automatic t_src();
    logic t;
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 3; k++) begin
        wr(addr_shutdown_ctl, 32'({1'b0, s[2:0], 4'h1}));
        @(posedge i_clk);
        c1 <= (k == 0);
        c2 <= (k == 1);
        flt_b <= (k != 2);
        #1;
        t = (k == 0 && s[0]) || (k == 1 && s[1]) || (k == 2 && s[2]);
        chk("force", t ? 32'hfa : 32'hff, 32'(pv()));
        cyc(8);
        rd(addr_shutdown_ctl);
        chk("flag", 32'(t), 32'(q[7]));
        chk("held", t ? 32'hfa : 32'hff, 32'(pv()));
        @(posedge i_clk);
        c1 <= 1'b0;
        c2 <= 1'b0;
        flt_b <= 1'b1;
        cyc(8);
        wr(addr_shutdown_ctl, 32'h01);
        cyc(40);
        chk("resume", 32'hff, 32'(pv()));
      end
    end
    $display("test sources done");
  endtask

  task automatic t_hold();
    wr(addr_shutdown_ctl, 32'h41);
    @(posedge i_clk);
    flt_b <= 1'b0;
    cyc(8);
    wr(addr_shutdown_ctl, 32'h41);
    rd(addr_shutdown_ctl);
    chk("wr_ignored", 32'h1, 32'(q[7]));
    @(posedge i_clk);
    flt_b <= 1'b1;
    cyc(20);
    rd(addr_shutdown_ctl);
    chk("stay_flag", 32'h1, 32'(q[7]));
    chk("stay_pins", 32'hfa, 32'(pv()));
    align();
    wr(addr_shutdown_ctl, 32'h01);
    chk("wait_period", 32'hf0, 32'(pv()));
    cyc(20);
    chk("restarted", 32'hff, 32'(pv()));
    wr(addr_shutdown_ctl, 32'h84);
    cyc(2);
    chk("sw_force", 32'hf5, 32'(pv()));
    rd(addr_shutdown_ctl);
    chk("sw_flag", 32'h1, 32'(q[7]));
    wr(addr_shutdown_ctl, 32'h01);
    $display("test hold done");
  endtask

  task automatic t_auto();
    wr(addr_restart_ctl, 32'h80);
    wr(addr_shutdown_ctl, 32'h21);
    @(posedge i_clk);
    c2 <= 1'b1;
    cyc(8);
    rd(addr_shutdown_ctl);
    chk("auto_set", 32'h1, 32'(q[7]));
    @(posedge i_clk);
    c2 <= 1'b0;
    cyc(40);
    rd(addr_shutdown_ctl);
    chk("auto_clr", 32'h0, 32'(q[7]));
    chk("auto_pins", 32'hff, 32'(pv()));
    wr(addr_restart_ctl, 32'h0);
    $display("test auto done");
  endtask

  task automatic t_steer_sd();
    port <= 4'h6;
    wr(addr_steer_ctl, 32'h03);
    wr(addr_shutdown_ctl, 32'h8a);
    cyc(2);
    chk("steer_sd", 32'hc4, 32'(pv()));
    wr(addr_shutdown_ctl, 32'h0a);
    wr(addr_steer_ctl, 32'h0f);
    port <= 4'h0;
    $display("test steer shutdown done");
  endtask

  task automatic t_dead();
    logic [31:0] na;
    logic [31:0] nb;
    int db;
    duty <= 5'h08;
    wr(addr_mode_ctl, 32'(6'h2c));
    for (int i = 0; i < 3; i++) begin
      db = i * 5;
      wr(addr_restart_ctl, 32'(db));
      cyc(40);
      na = 0;
      nb = 0;
      repeat (16) begin
        cyc(1);
        na += 32'(wire_lvl[0]);
        nb += 32'(wire_lvl[1]);
      end
      chk("db_a", (db > 8) ? 0 : 8 - db, na);
      chk("db_b", (db > 8) ? 0 : 8 - db, nb);
    end
    $display("test deadband done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge i_clk);
    rst_b <= 1'b1;
    t_regs();
    t_steer();
    t_src();
    t_hold();
    t_auto();
    t_steer_sd();
    t_dead();
    print_verdict();
  end
endmodule
